// File: hdl/bus_exc_device.sv
// Device end: cycle termination, retry, halt, double fault and bus arbiter
`timescale 1ns/1ps
module bus_exc_device
  import bus_exc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Core requests
  input wire logic req_valid,
  input wire logic [bus_exc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [bus_exc_pkg::FC_W-1:0] req_fc,
  input wire logic [bus_exc_pkg::SIZE_W-1:0] req_size,
  input wire logic req_rw,
  input wire logic [bus_exc_pkg::DATA_W-1:0] req_wdata,
  input wire logic [bus_exc_pkg::CS_W-1:0] req_cs,
  input wire logic req_locked,
  input wire logic req_last,
  input wire logic req_prefetch,
  output logic req_ready,
  // Answers
  output logic done,
  output logic done_error,
  output logic [bus_exc_pkg::DATA_W-1:0] rdata,
  // Prefetch and exceptions
  input wire logic use_word,
  input wire logic discard_word,
  input wire logic exc_active,
  input wire logic addr_error,
  output logic exc_request,
  output logic prefetch_fault,
  output logic double_fault,
  output logic irq_enable,
  // External bus
  bus_exc_if.device bus
);
  import bus_exc_pkg::*;

  // ==========================================
  // Input synchronisers
  logic [SYNC_W-1:0] meta;
  logic [SYNC_W-1:0] sync;
  logic err_s, ack_s, halt_s, br_s, gack_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
    end else if (ce) begin
      meta <= {bus.bus_error_in, bus.cycle_ack, bus.halt_line, bus.bus_request, bus.grant_ack};
      sync <= meta;
    end
  end
  assign {err_s, ack_s, halt_s, br_s, gack_s} = sync;

  // ==========================================
  // Cycle state
  cyc_state_type cyc;
  arb_state_type arb;
  logic own, can_start, term_retry, term_error, term_ok, retry_clear, yield;
  logic cur_rw, cur_last, cur_prefetch, cur_locked, op_open, pend;
  logic [DATA_W-1:0] cur_wdata;
  logic bus_err_evt;

  assign own = (arb == ARB_OWN);
  // Halt or stale termination blocks a new cycle at the boundary
  // A grant being issued this edge keeps a new cycle from starting beside it
  assign yield = br_s && grant_ok;
  assign can_start = own && !yield && !halt_s && !err_s && !ack_s && !double_fault;
  assign req_ready = (cyc == CYC_IDLE) && can_start;
  // Error beats acknowledge; error with halt is a retry
  assign term_retry = err_s && halt_s && !cur_locked_abort();
  assign term_error = err_s && !term_retry;
  assign term_ok = ack_s && !err_s;
  assign retry_clear = !err_s && !halt_s;

  // Inside a locked sequence an error with request but no halt aborts; an error with halt still retries
  function automatic logic cur_locked_abort();
    cur_locked_abort = bus.locked_cycle && br_s && !halt_s;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc <= CYC_IDLE;
    end else if (ce) begin
      case (cyc)
        CYC_IDLE: begin
          if (req_valid && can_start) begin
            cyc <= CYC_RUN;
          end
        end
        CYC_RUN: begin
          if (err_s) begin
            cyc <= term_retry ? CYC_RETRY : CYC_IDLE;
          end else if (ack_s) begin
            cyc <= CYC_LATE;
          end
        end
        CYC_LATE: begin
          // Late error or retry one clock after acknowledge
          if (term_retry) begin
            cyc <= CYC_RETRY;
          end else begin
            cyc <= CYC_IDLE;
          end
        end
        CYC_RETRY: begin
          // Repeat with held address, code and size, as often as asked
          if (retry_clear && own && !yield && !double_fault) begin
            cyc <= CYC_RUN;
          end
        end
        default: cyc <= CYC_IDLE;
      endcase
    end
  end

  // ==========================================
  // Held access information
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.addr <= '0;
      bus.function_code <= '0;
      bus.transfer_size <= '0;
      cur_rw <= 1'b1;
      cur_wdata <= '0;
      cur_last <= 1'b1;
      cur_prefetch <= 1'b0;
      bus.chip_select_outs <= CS_IDLE;
    end else if (ce) begin
      if (cyc == CYC_IDLE && req_valid && can_start) begin
        bus.addr <= req_addr;
        bus.function_code <= req_fc;
        bus.transfer_size <= req_size;
        cur_rw <= req_rw;
        cur_wdata <= req_wdata;
        cur_last <= req_last;
        cur_prefetch <= req_prefetch;
        bus.chip_select_outs <= req_cs;
      end else if (cyc == CYC_IDLE) begin
        bus.chip_select_outs <= CS_IDLE;
      end
    end
  end

  // Lock and operand coherency
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_locked <= 1'b0;
      op_open <= 1'b0;
    end else if (ce) begin
      if (cyc == CYC_IDLE && req_valid && can_start) begin
        cur_locked <= req_locked;
        op_open <= !req_last;
      end else if ((cyc == CYC_RUN && term_error) || (cyc == CYC_LATE && !term_retry &&
                   (err_s || cur_last))) begin
        cur_locked <= 1'b0;
        op_open <= 1'b0;
      end
    end
  end
  assign bus.locked_cycle = cur_locked;

  // ==========================================
  // Answers and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      done_error <= 1'b0;
      rdata <= '0;
    end else if (ce) begin
      done <= ((cyc == CYC_RUN) && term_error) || ((cyc == CYC_LATE) && !term_retry);
      done_error <= ((cyc == CYC_RUN) && term_error) || ((cyc == CYC_LATE) && term_error);
      if (cyc == CYC_RUN && term_ok && cur_rw) begin
        rdata <= bus.data_line;
      end
    end
  end
  assign bus_err_evt = done_error; // Retries never reach here

  // Deferred prefetch error; a new error wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= 1'b0;
    end else if (ce) begin
      if (bus_err_evt && cur_prefetch) begin
        pend <= 1'b1;
      end else if (use_word || discard_word) begin
        pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      exc_request <= 1'b0;
      prefetch_fault <= 1'b0;
    end else if (ce) begin
      exc_request <= (bus_err_evt && !cur_prefetch && !exc_active) ||
                     (pend && use_word && !discard_word);
      prefetch_fault <= pend && use_word && !discard_word;
    end
  end

  // Double fault halts until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      double_fault <= 1'b0;
    end else if (ce) begin
      if (exc_active && ((bus_err_evt && !cur_prefetch) || addr_error)) begin
        double_fault <= 1'b1;
      end
    end
  end
  assign bus.dev_halt_out = double_fault;
  assign bus.dev_halt_oe = double_fault;
  assign irq_enable = !halt_s && !double_fault;

  // ==========================================
  // Pin drive
  assign bus.addr_oe = own;
  assign bus.strobe = (cyc == CYC_RUN) || (cyc == CYC_LATE);
  assign bus.rw = cur_rw;
  assign bus.dev_data = cur_wdata;
  assign bus.dev_data_oe = own && bus.strobe && !cur_rw;

  // ==========================================
  // Bus arbiter
  logic grant_ok;
  logic [1:0] dly;
  assign grant_ok = !cur_locked && (((cyc == CYC_IDLE) && !op_open) || (cyc == CYC_RETRY));

  always_ff @(posedge clk) begin
    if (rst) begin
      arb <= ARB_OWN;
      dly <= '0;
    end else if (ce) begin
      case (arb)
        ARB_OWN: begin
          dly <= '0;
          if (br_s && grant_ok) begin
            arb <= ARB_OFFER;
          end
        end
        ARB_OFFER: begin
          dly <= '0;
          if (gack_s) begin
            arb <= ARB_HANDOVER;
          end else if (!br_s) begin
            arb <= ARB_OWN;
          end
        end
        ARB_HANDOVER: begin
          dly <= dly + 2'h1;
          if (dly == GRANT_DLY) begin
            arb <= ARB_EXT;
            dly <= '0;
          end
        end
        ARB_EXT: begin
          if (!gack_s) begin
            arb <= br_s ? ARB_OFFER : ARB_OWN;
            dly <= '0;
          end else if (br_s) begin
            dly <= dly + 2'h1;
            if (dly == GRANT_DLY) begin
              arb <= ARB_REOFFER;
            end
          end else begin
            dly <= '0;
          end
        end
        ARB_REOFFER: begin
          dly <= '0;
          if (!gack_s) begin
            arb <= ARB_OFFER;
          end else if (!br_s) begin
            arb <= ARB_EXT;
          end
        end
        default: arb <= ARB_OWN;
      endcase
    end
  end
  assign bus.bus_grant = (arb == ARB_OFFER) || (arb == ARB_HANDOVER) || (arb == ARB_REOFFER);
endmodule

// File: hdl/bus_exc_pkg.sv
// Shared constants and types for the bus exception and arbitration ends
package bus_exc_pkg;
  // ==========================================
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int FC_W = 3;
  localparam int SIZE_W = 2;
  localparam int CS_W = 4;
  localparam int SYNC_W = 5;
  localparam int HSYNC_W = 3;
  // ==========================================
  // Reset values and timing
  localparam logic [CS_W-1:0] CS_IDLE = 4'h0;
  localparam logic [1:0] GRANT_DLY = 2'h2;
  localparam logic [3:0] WAIT_ZERO = 4'h0;
  // ==========================================
  // Enumerations
  typedef enum {CYC_IDLE, CYC_RUN, CYC_LATE, CYC_RETRY} cyc_state_type;
  typedef enum {ARB_OWN, ARB_OFFER, ARB_HANDOVER, ARB_EXT, ARB_REOFFER} arb_state_type;
  typedef enum {R_IDLE, R_WAIT, R_LATE, R_TERM} resp_state_type;
  typedef enum {M_IDLE, M_REQ, M_OWN} master_state_type;
  typedef enum logic [2:0] {
    RESP_NORMAL, RESP_HALT, RESP_ERROR, RESP_RETRY,
    RESP_LATE_ERROR, RESP_LATE_RETRY, RESP_RELINQUISH
  } resp_mode_type;
endpackage

// File: hdl/bus_exc_if.sv
// External bus wires between the device end and the external logic end
`timescale 1ns/1ps
interface bus_exc_if;
  import bus_exc_pkg::*;
  // ==========================================
  // Device driven
  logic [ADDR_W-1:0] addr;
  logic [FC_W-1:0] function_code;
  logic [SIZE_W-1:0] transfer_size;
  logic rw;
  logic addr_oe;
  logic strobe;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic dev_halt_out;
  logic dev_halt_oe;
  logic bus_grant;
  logic locked_cycle;
  logic [CS_W-1:0] chip_select_outs;
  // ==========================================
  // External logic driven
  logic [DATA_W-1:0] host_data;
  logic host_data_oe;
  logic cycle_ack;
  logic bus_error_in;
  logic host_halt_out;
  logic host_halt_oe;
  logic bus_request;
  logic grant_ack;
  // ==========================================
  // Resolved wires
  logic [DATA_W-1:0] data_line;
  logic halt_line;
  logic strobe_line;
  assign data_line = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);
  assign halt_line = (dev_halt_oe & dev_halt_out) | (host_halt_oe & host_halt_out);
  assign strobe_line = addr_oe & strobe;

  modport device (
    output addr, function_code, transfer_size, rw, addr_oe, strobe, dev_data, dev_data_oe,
    output dev_halt_out, dev_halt_oe, bus_grant, locked_cycle, chip_select_outs,
    input data_line, halt_line, cycle_ack, bus_error_in, bus_request, grant_ack
  );
  modport host (
    output host_data, host_data_oe, cycle_ack, bus_error_in, host_halt_out, host_halt_oe,
    output bus_request, grant_ack,
    input addr, function_code, transfer_size, rw, strobe_line, bus_grant, locked_cycle,
    input chip_select_outs, data_line
  );
endinterface

// File: hdl/bus_exc_host.sv
// External logic end: cycle responder and alternate bus master
`timescale 1ns/1ps
module bus_exc_host
  import bus_exc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Responder control
  input wire bus_exc_pkg::resp_mode_type resp_mode,
  input wire logic [3:0] ack_wait,
  input wire logic [bus_exc_pkg::DATA_W-1:0] read_data,
  input wire logic step_halt,
  output logic cycle_seen,
  // Master control
  input wire logic master_req,
  output logic master_owns,
  // External bus
  bus_exc_if.host bus
);
  import bus_exc_pkg::*;

  // ==========================================
  // Input synchronisers
  logic [HSYNC_W-1:0] meta;
  logic [HSYNC_W-1:0] sync;
  logic strobe_s, grant_s, lock_s;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
    end else if (ce) begin
      meta <= {bus.strobe_line, bus.bus_grant, bus.locked_cycle};
      sync <= meta;
    end
  end
  assign {strobe_s, grant_s, lock_s} = sync;

  // ==========================================
  // Responder
  resp_state_type rs;
  resp_mode_type mode;
  logic [3:0] cnt;
  logic ack, err, halt_t, rel_req;
  always_ff @(posedge clk) begin
    if (rst) begin
      rs <= R_IDLE;
      mode <= RESP_NORMAL;
      cnt <= WAIT_ZERO;
      ack <= 1'b0;
      err <= 1'b0;
      halt_t <= 1'b0;
      rel_req <= 1'b0;
      cycle_seen <= 1'b0;
    end else if (ce) begin
      cycle_seen <= 1'b0;
      if (rel_req && grant_s) begin
        rel_req <= 1'b0;
      end
      case (rs)
        R_IDLE: begin
          cnt <= WAIT_ZERO;
          if (strobe_s) begin
            mode <= resp_mode;
            rs <= R_WAIT;
          end
        end
        R_WAIT: begin
          cnt <= cnt + 4'h1;
          if (cnt == ack_wait) begin
            rs <= R_TERM;
            case (mode)
              RESP_NORMAL: ack <= 1'b1;
              RESP_HALT: begin
                ack <= 1'b1;
                halt_t <= 1'b1;
              end
              RESP_ERROR: err <= 1'b1;
              RESP_RETRY: begin
                err <= 1'b1;
                halt_t <= !lock_s;
              end
              RESP_RELINQUISH: begin
                err <= 1'b1;
                halt_t <= !lock_s;
                rel_req <= 1'b1;
              end
              default: begin
                ack <= 1'b1;
                rs <= R_LATE;
              end
            endcase
          end
        end
        R_LATE: begin
          // Error follows acknowledge by one clock and stays stable
          err <= 1'b1;
          halt_t <= (mode == RESP_LATE_RETRY);
          rs <= R_TERM;
        end
        R_TERM: begin
          if (!strobe_s) begin
            ack <= 1'b0;
            err <= 1'b0;
            halt_t <= 1'b0;
            cycle_seen <= 1'b1;
            rs <= R_IDLE;
          end
        end
        default: rs <= R_IDLE;
      endcase
    end
  end
  assign bus.cycle_ack = ack;
  assign bus.bus_error_in = err;
  assign bus.host_halt_out = halt_t || step_halt;
  assign bus.host_halt_oe = halt_t || step_halt;
  assign bus.host_data = read_data;
  assign bus.host_data_oe = ack && bus.rw;

  // ==========================================
  // Alternate master
  master_state_type ms;
  always_ff @(posedge clk) begin
    if (rst) begin
      ms <= M_IDLE;
    end else if (ce) begin
      case (ms)
        M_IDLE: begin
          if (master_req) begin
            ms <= M_REQ;
          end
        end
        M_REQ: begin
          if (!master_req) begin
            ms <= M_IDLE;
          end else if (grant_s) begin
            ms <= M_OWN;
          end
        end
        M_OWN: begin
          if (!master_req) begin
            ms <= M_IDLE;
          end
        end
        default: ms <= M_IDLE;
      endcase
    end
  end
  assign master_owns = (ms == M_OWN);
  assign bus.grant_ack = (ms == M_OWN);
  assign bus.bus_request = (ms == M_REQ) || rel_req;
endmodule

// File: verif/bus_exc_chk.sv
// Concurrent checks on the bus between the device end and the external logic end
`timescale 1ns/1ps
module bus_exc_chk
  import bus_exc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus wires
  input wire logic [bus_exc_pkg::ADDR_W-1:0] addr,
  input wire logic [bus_exc_pkg::FC_W-1:0] function_code,
  input wire logic addr_oe,
  input wire logic strobe,
  input wire logic halt_line,
  input wire logic bus_error_in,
  input wire logic bus_grant,
  input wire logic grant_ack,
  input wire logic bus_request,
  input wire logic locked_cycle
);
  import bus_exc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [ADDR_W-1:0] last_addr;
  logic [FC_W-1:0] last_fc;
  logic retried;
  logic [3:0] req_age;
  // ==========================================
  // Helper state
  always_ff @(posedge clk) begin
    if (strobe) begin
      last_addr <= addr;
      last_fc <= function_code;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      retried <= 1'b0;
    end else if ($fell(strobe)) begin
      retried <= bus_error_in & halt_line;
    end else if ($rose(strobe)) begin
      retried <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || bus_request) begin
      req_age <= 4'h0;
    end else if (req_age != 4'hf) begin
      req_age <= req_age + 4'h1;
    end
  end
  // ==========================================
  // Assertions
  a_grant_after_lock: assert property ($rose(bus_grant) |-> !locked_cycle)
    else $error("grant raised during locked sequence");
  a_grant_has_cause: assert property ($rose(bus_grant) |-> req_age < 4'h6)
    else $error("grant raised without a request");
  a_grant_drops: assert property (bus_grant && $rose(grant_ack) |-> ##[1:8] !bus_grant)
    else $error("grant not negated after acknowledge");
  a_ext_floats: assert property (grant_ack |-> !addr_oe && !strobe)
    else $error("device drives bus while granted away");
  a_req_with_ack: assert property ($rose(grant_ack) |-> !bus_request)
    else $error("request kept after acknowledge");
  a_retry_quiet: assert property (strobe && bus_error_in && halt_line |-> ##[1:6] !strobe)
    else $error("retry did not end the cycle");
  a_retry_same: assert property ($rose(strobe) && retried |->
    addr == last_addr && function_code == last_fc)
    else $error("retried cycle changed its access");
  a_lock_in_retry: assert property ($fell(strobe) && locked_cycle && bus_error_in && halt_line |=> locked_cycle)
    else $error("lock dropped during retry");
  a_halt_holds: assert property ($rose(strobe) |->
    !($past(halt_line, 2) && $past(halt_line, 3) && $past(halt_line, 4)))
    else $error("cycle started while halted");
  // ==========================================
  // Coverage
  c_handover: cover property ($rose(grant_ack));
  c_retry: cover property ($rose(strobe) && retried);
  c_error: cover property ($fell(strobe) && bus_error_in && !halt_line);
endmodule

// File: verif/tb.sv
// Self-checking bench for the device end facing the external logic end
`timescale 1ns/1ps
module tb;
  import bus_exc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0, req_rw = 1'b1, req_locked = 1'b0, req_last = 1'b1, req_prefetch = 1'b0;
  logic [ADDR_W-1:0] req_addr = 32'h0;
  logic [FC_W-1:0] req_fc = 3'h0;
  logic [SIZE_W-1:0] req_size = 2'h1;
  logic [DATA_W-1:0] req_wdata = 16'h0, read_data = 16'h0, rdata;
  logic [CS_W-1:0] req_cs = 4'h0;
  logic use_word = 1'b0, discard_word = 1'b0, exc_active = 1'b0, addr_error = 1'b0;
  logic step_halt = 1'b0, master_req = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  resp_mode_type resp_mode = RESP_NORMAL;
  logic req_ready, done, done_error, exc_request, prefetch_fault, double_fault, irq_enable;
  logic master_owns;
  int error_cnt = 0;
  int n_checks = 0;
  int n, hits;
  always #2.5 clk = ~clk;
  bus_exc_if bif();
  bus_exc_device i_bus_exc_device(.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid),
    .req_addr(req_addr), .req_fc(req_fc), .req_size(req_size), .req_rw(req_rw),
    .req_wdata(req_wdata), .req_cs(req_cs), .req_locked(req_locked), .req_last(req_last),
    .req_prefetch(req_prefetch), .req_ready(req_ready), .done(done), .done_error(done_error),
    .rdata(rdata), .use_word(use_word), .discard_word(discard_word), .exc_active(exc_active),
    .addr_error(addr_error), .exc_request(exc_request), .prefetch_fault(prefetch_fault),
    .double_fault(double_fault), .irq_enable(irq_enable), .bus(bif.device));
  bus_exc_host i_bus_exc_host(.clk(clk), .rst(rst), .ce(ce), .resp_mode(resp_mode),
    .ack_wait(ack_wait), .read_data(read_data), .step_halt(step_halt), .cycle_seen(),
    .master_req(master_req), .master_owns(master_owns), .bus(bif.host));
  bus_exc_chk i_bus_exc_chk(.clk(clk), .rst(rst), .addr(bif.addr),
    .function_code(bif.function_code), .addr_oe(bif.addr_oe), .strobe(bif.strobe),
    .halt_line(bif.halt_line), .bus_error_in(bif.bus_error_in), .bus_grant(bif.bus_grant),
    .grant_ack(bif.grant_ack), .bus_request(bif.bus_request), .locked_cycle(bif.locked_cycle));
  // ==========================================
  // Tasks
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("Checks: %0d, errors: %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input logic [31:0] a, input logic rw, input logic lk, input logic last,
      input logic pf, input resp_mode_type m, input int hold);
    int k;
    k = 0;
    @(posedge clk);
    req_addr <= a;
    req_fc <= a[2:0];
    req_rw <= rw;
    req_wdata <= a[15:0];
    req_cs <= a[3:0];
    req_locked <= lk;
    req_last <= last;
    req_prefetch <= pf;
    resp_mode <= m;
    read_data <= ~a[15:0];
    req_valid <= 1'b1;
    if (hold > 0) begin
      repeat (hold) @(negedge clk);
      check(bif.strobe_line === 1'b0, "cycle ran while halted");
      @(posedge clk);
      step_halt <= 1'b0;
    end
    do @(negedge clk); while (req_ready !== 1'b1 && ++k < 300);
    @(posedge clk);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      if (k == 4) resp_mode <= RESP_NORMAL;
      @(negedge clk);
    end while (done !== 1'b1 && ++k < 400);
    check(k < 400, "cycle never ended");
  endtask
  task automatic watch(input int cycles);
    hits = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (prefetch_fault === 1'b1) hits++;
    end
  endtask
  // ==========================================
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
  // ==========================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      ack_wait <= 4'(i);
      cyc(32'h1000 + i, 1'b1, 1'b0, 1'b1, 1'b0, resp_mode_type'(i), 0);
      check(done_error === (i == 2 || i == 4), "wrong termination");
      if (i != 2 && i != 4) check(rdata === ~(16'h1000 + 16'(i)), "bad read data");
    end
    check(double_fault === 1'b0, "double fault outside exception");
    cyc(32'h100, 1'b1, 1'b0, 1'b1, 1'b1, RESP_ERROR, 0);
    watch(8);
    check(hits == 0, "prefetch fault raised early");
    @(posedge clk);
    use_word <= 1'b1;
    watch(8);
    use_word <= 1'b0;
    check(hits == 1, "prefetch fault not raised on use");
    cyc(32'h104, 1'b1, 1'b0, 1'b1, 1'b1, RESP_ERROR, 0);
    @(posedge clk);
    discard_word <= 1'b1;
    @(posedge clk);
    discard_word <= 1'b0;
    use_word <= 1'b1;
    watch(8);
    use_word <= 1'b0;
    check(hits == 0, "fault raised for discarded word");
    step_halt <= 1'b1;
    repeat (5) @(posedge clk);
    check(irq_enable === 1'b0, "interrupts open while halted");
    cyc(32'h200, 1'b0, 1'b0, 1'b1, 1'b0, RESP_NORMAL, 20);
    check(done_error === 1'b0, "halted write failed");
    cyc(32'h300, 1'b1, 1'b1, 1'b0, 1'b0, RESP_NORMAL, 0);
    master_req <= 1'b1;
    repeat (10) @(posedge clk);
    check(bif.bus_grant === 1'b0, "granted inside operand");
    cyc(32'h300, 1'b0, 1'b1, 1'b1, 1'b0, RESP_NORMAL, 0);
    n = 0;
    while (master_owns !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check(master_owns === 1'b1, "handover failed");
    check(bif.addr_oe === 1'b0, "address driven while granted");
    check(bif.bus_request === 1'b0, "request kept with acknowledge");
    @(posedge clk);
    master_req <= 1'b0;
    repeat (12) @(posedge clk);
    check(bif.addr_oe === 1'b1, "bus not regained");
    exc_active <= 1'b1;
    cyc(32'h400, 1'b1, 1'b0, 1'b1, 1'b0, RESP_ERROR, 0);
    repeat (4) @(negedge clk);
    check(double_fault === 1'b1, "no double fault");
    check(bif.halt_line === 1'b1 && req_ready === 1'b0, "double fault not halted");
    @(posedge clk);
    master_req <= 1'b1;
    n = 0;
    while (master_owns !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check(master_owns === 1'b1, "no arbitration after double fault");
    @(posedge clk);
    master_req <= 1'b0;
    exc_active <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(double_fault === 1'b0, "reset did not clear fault");
    cyc(32'h500, 1'b1, 1'b0, 1'b1, 1'b0, RESP_NORMAL, 0);
    check(rdata === 16'hfaff, "read after reset failed");
    final_report();
  end
endmodule
